/* File: cpsf_alu_if.sv */
`timescale 1ns/1ps

interface cpsf_alu_if #(
  parameter int W = 8
);
  import cpsf_pkg::*;

  cpsf_op_type op;
  logic [W-1:0] opnd_a;
  logic [W-1:0] opnd_b;
  logic carry_in;
  logic [W-1:0] result;
  logic carry_out;
  logic digit_out;
  logic zero_out;

  // Core side drives operands, datapath answers
  modport core (output op, opnd_a, opnd_b, carry_in,
                input result, carry_out, digit_out, zero_out);
  modport alu (input op, opnd_a, opnd_b, carry_in,
               output result, carry_out, digit_out, zero_out);
endinterface

/* File: cpsf_core_model.sv */
`timescale 1ns/1ps

module cpsf_core_model
  import cpsf_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Instruction pins
  output logic op_valid_o,
  output cpsf_op_type op_kind_o,
  output logic dest_o,
  output logic [7:0] a_o,
  output logic [7:0] b_o,
  // Event pins
  output logic clear_o,
  output logic sleep_o,
  output logic timeout_o
);
  ////////////////////////////////////////////////////////////////////////
  // Idle pins at time zero
  initial begin
    op_valid_o = 1'b0;
    op_kind_o = CPSF_OP_WRITE;
    dest_o = 1'b0;
    a_o = 8'h00;
    b_o = 8'h00;
    clear_o = 1'b0;
    sleep_o = 1'b0;
    timeout_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One instruction, held across one rising edge
  // Register alterations use the flag-neutral write class
  task automatic run_op(input cpsf_op_type k, input logic d,
                        input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_i);
    op_valid_o = 1'b1;
    op_kind_o = k;
    dest_o = d;
    a_o = a;
    b_o = b;
    @(negedge clk_i);
    op_valid_o = 1'b0;
    a_o = ~a; // Stale operands must not linger
    b_o = ~b;
  endtask

  // One-cycle event pulses
  task automatic run_ev(input logic c, input logic s, input logic t);
    @(negedge clk_i);
    clear_o = c;
    sleep_o = s;
    timeout_o = t;
    @(negedge clk_i);
    clear_o = 1'b0;
    sleep_o = 1'b0;
    timeout_o = 1'b0;
  endtask

  // Sleep, then watchdog clear on the very next edge
  task automatic run_pair;
    @(negedge clk_i);
    sleep_o = 1'b1;
    @(negedge clk_i);
    sleep_o = 1'b0;
    clear_o = 1'b1;
    @(negedge clk_i);
    clear_o = 1'b0;
  endtask
endmodule

/* File: cpsf_flag_alu.sv */
`timescale 1ns/1ps

module cpsf_flag_alu
  import cpsf_pkg::*;
#(
  parameter int W = 8
) (
  // Operand and flag channel
  cpsf_alu_if.alu bus
);

  // Refuse widths of one nibble or less
  generate
    if (W < 5) begin : g_chk
      $error("cpsf_flag_alu: W must be at least 5");
    end
  endgenerate

  logic [W:0] sum_w;
  logic [4:0] nib_w;
  logic [W-1:0] res_w;

  ////////////////////////////////////////////////////////////////////////
  // Result and carries; subtract adds the two's complement of A
  always_comb begin
    sum_w = '0;
    nib_w = '0;
    res_w = bus.opnd_b;
    bus.carry_out = 1'b0;
    case (bus.op)
      CPSF_OP_ADD: begin
        sum_w = {1'b0, bus.opnd_b} + {1'b0, bus.opnd_a};
        nib_w = {1'b0, bus.opnd_b[3:0]} + {1'b0, bus.opnd_a[3:0]};
        res_w = sum_w[W-1:0];
        bus.carry_out = sum_w[W];
      end
      CPSF_OP_SUB: begin
        sum_w = {1'b0, bus.opnd_b} + {1'b0, ~bus.opnd_a}
          + {{W{1'b0}}, 1'b1}; // see RQ10
        nib_w = {1'b0, bus.opnd_b[3:0]} + {1'b0, ~bus.opnd_a[3:0]}
          + 5'h01; // see RQ10
        res_w = sum_w[W-1:0];
        bus.carry_out = sum_w[W];
      end
      CPSF_OP_RRF: begin
        res_w = {bus.carry_in, bus.opnd_b[W-1:1]};
        bus.carry_out = bus.opnd_b[0]; // see RQ11
      end
      CPSF_OP_RLF: begin
        res_w = {bus.opnd_b[W-2:0], bus.carry_in};
        bus.carry_out = bus.opnd_b[W-1]; // see RQ11
      end
      default: begin
        res_w = bus.opnd_b;
        bus.carry_out = 1'b0;
      end
    endcase
  end

  // Outputs toward the flag register
  assign bus.result = res_w;
  assign bus.digit_out = nib_w[4]; // see RQ8
  assign bus.zero_out = (res_w == '0); // see RQ7

endmodule

/* File: cpsf_map.svh */
`ifndef CPSF_MAP_SVH
`define CPSF_MAP_SVH

// Bit positions inside the flags register
`define CPSF_TO_BIT 4
`define CPSF_PD_BIT 3
`define CPSF_Z_BIT 2
`define CPSF_DC_BIT 1
`define CPSF_C_BIT 0

// Value after power-on or brown-out reset
`define CPSF_RESET_VAL 8'h18

// Implemented bits; bits 7-5 are always zero
`define CPSF_IMPL_MASK 8'h1F

`endif

/* File: cpsf_pkg.sv */
package cpsf_pkg;

  // Instruction classes seen by the flag logic
  typedef enum logic [2:0] {
    CPSF_OP_WRITE = 3'b000, // Flag-neutral write (store, bit ops, swap)
    CPSF_OP_ADD = 3'b001, // Add register or literal
    CPSF_OP_SUB = 3'b010, // Subtract literal or register
    CPSF_OP_RRF = 3'b011, // Rotate right through carry
    CPSF_OP_RLF = 3'b100, // Rotate left through carry
    CPSF_OP_ZONLY = 3'b101 // Logic or clear op, zero flag only
  } cpsf_op_type;

endpackage

/* File: cpsf_status_reg.sv */
// Operation
// RQ1 - Flag ops aimed here: flag logic wins
// RQ2 - Instruction writes never touch expiry, sleep
// RQ3 - Software alters register with flag-neutral ops
// RQ4 - Bits 7-5 read zero, writes dropped
// RQ5 - Expiry set: power-up, clear, sleep; timeout clears
// RQ6 - Sleep flag set: power-up, clear; sleep clears
// RQ7 - Zero flag follows result of flag ops (rotates leave it unchanged)
// RQ8 - Nibble flag is carry from bit 3
// RQ9 - Msb flag is carry from top bit
// RQ10 - Subtract adds two's complement; flags mean no-borrow
// RQ11 - Rotates load msb flag with shifted-out bit
// RQ12 - Power-on loads 0x18; others keep ALU flags (RESETN_I also loads 0x18, clearing them)
// RQ13 - Flag-neutral writes store the three ALU bits
`include "cpsf_map.svh"
`timescale 1ns/1ps

module cpsf_status_reg
  import cpsf_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic POR_I,
  // Instruction from the execution unit
  input wire logic OP_VALID_I,
  input wire cpsf_op_type OP_KIND_I,
  input wire logic DEST_FLAGS_I,
  input wire logic [W-1:0] OPND_A_I,
  input wire logic [W-1:0] OPND_B_I,
  // Core events
  input wire logic WDT_CLEAR_I,
  input wire logic SLEEP_I,
  input wire logic WDT_TIMEOUT_I,
  // Register and result
  output logic [7:0] FLAGS_O,
  output logic [W-1:0] RESULT_O,
  output logic RESULT_VALID_O
);

  generate
    if (W != 8) begin : g_chk
      $error("cpsf_status_reg: register is eight bits wide");
    end
  endgenerate

  cpsf_alu_if #(.W(W)) alu_bus ();

  localparam logic [7:0] RST_VAL = `CPSF_RESET_VAL;

  logic [2:0] alu_q;
  logic [4:3] cause_q;
  logic [7:5] upper_q;
  logic [W-1:0] result_q;
  logic result_vld_q;
  logic flag_op_w;
  logic wr_here_w;

  ////////////////////////////////////////////////////////////////////////
  // Datapath
  assign alu_bus.op = OP_KIND_I;
  assign alu_bus.opnd_a = OPND_A_I;
  assign alu_bus.opnd_b = OPND_B_I;
  assign alu_bus.carry_in = alu_q[`CPSF_C_BIT];

  cpsf_flag_alu #(.W(W)) u_alu (
    .bus (alu_bus.alu)
  );

  // Classify the instruction
  assign flag_op_w = (OP_KIND_I != CPSF_OP_WRITE);
  assign wr_here_w = OP_VALID_I && DEST_FLAGS_I;

  ////////////////////////////////////////////////////////////////////////
  // ALU flags: zero, nibble overflow, msb overflow
  // Flag ops aimed here take flags from logic, never from data
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      alu_q <= RST_VAL[2:0]; // see RQ12
    end else if (POR_I) begin
      alu_q <= RST_VAL[2:0]; // see RQ12
    end else if (OP_VALID_I) begin
      case (OP_KIND_I)
        CPSF_OP_ADD, CPSF_OP_SUB: begin // see RQ1
          alu_q[`CPSF_Z_BIT] <= alu_bus.zero_out; // see RQ7
          alu_q[`CPSF_DC_BIT] <= alu_bus.digit_out; // see RQ8
          alu_q[`CPSF_C_BIT] <= alu_bus.carry_out; // see RQ9
        end
        CPSF_OP_RRF, CPSF_OP_RLF: begin // see RQ1
          alu_q[`CPSF_C_BIT] <= alu_bus.carry_out; // see RQ11
        end
        CPSF_OP_ZONLY: begin // see RQ1
          alu_q[`CPSF_Z_BIT] <= alu_bus.zero_out; // see RQ7
        end
        default: begin
          if (DEST_FLAGS_I) begin
            alu_q <= alu_bus.result[2:0]; // see RQ13
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset-cause flags; instruction data never reaches them
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cause_q <= RST_VAL[4:3]; // see RQ12
    end else if (POR_I) begin
      cause_q <= RST_VAL[4:3]; // see RQ12
    end else begin // see RQ2
      if (WDT_TIMEOUT_I) begin
        cause_q[`CPSF_TO_BIT] <= 1'b0; // see RQ5
      end else if (WDT_CLEAR_I || SLEEP_I) begin
        cause_q[`CPSF_TO_BIT] <= 1'b1; // see RQ5
      end
      if (WDT_CLEAR_I) begin
        cause_q[`CPSF_PD_BIT] <= 1'b1; // see RQ6
      end else if (SLEEP_I) begin
        cause_q[`CPSF_PD_BIT] <= 1'b0; // see RQ6
      end
    end
  end

  // Unimplemented bits held at zero
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      upper_q <= RST_VAL[7:5]; // see RQ4
    end else begin
      upper_q <= RST_VAL[7:5]; // see RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result register back to the execution unit
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      result_q <= '0;
      result_vld_q <= 1'b0;
    end else begin
      result_vld_q <= OP_VALID_I && !POR_I;
      if (OP_VALID_I) begin
        result_q <= alu_bus.result;
      end
    end
  end

  // Register image from its three flop groups
  assign FLAGS_O = {upper_q, cause_q, alu_q};
  assign RESULT_O = result_q;
  assign RESULT_VALID_O = result_vld_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);

  logic [W:0] chk_add_w;
  logic [4:0] chk_nib_w;
  assign chk_add_w = {1'b0, OPND_B_I} + {1'b0, OPND_A_I};
  assign chk_nib_w = {1'b0, OPND_B_I[3:0]} + {1'b0, OPND_A_I[3:0]};

  logic quiet_w;
  assign quiet_w = !POR_I && !WDT_CLEAR_I && !SLEEP_I && !WDT_TIMEOUT_I;

  sequence s_sleep;
    SLEEP_I && !WDT_CLEAR_I && !WDT_TIMEOUT_I && !POR_I;
  endsequence

  sequence s_wake_clear;
    WDT_CLEAR_I && !WDT_TIMEOUT_I && !POR_I;
  endsequence

  AST_UPPER_ZERO: assert property (FLAGS_O[7:5] == 3'h0) // see RQ4
    else $error("upper flag bits not zero");

  AST_POR_VALUE: assert property (POR_I |=> // see RQ12
    FLAGS_O == `CPSF_RESET_VAL)
    else $error("power-on value wrong");

  AST_SLEEP_CLEAR: assert property (s_sleep ##1 s_wake_clear |=> // see RQ6
    FLAGS_O[`CPSF_PD_BIT] && FLAGS_O[`CPSF_TO_BIT])
    else $error("clear after sleep did not set flags");

  AST_SLEEP: assert property (s_sleep |=> // see RQ5
    !FLAGS_O[`CPSF_PD_BIT] && FLAGS_O[`CPSF_TO_BIT])
    else $error("sleep flags wrong");

  AST_TIMEOUT: assert property (WDT_TIMEOUT_I && !POR_I |=> // see RQ5
    !FLAGS_O[`CPSF_TO_BIT])
    else $error("timeout did not clear expiry flag");

  AST_WRITE_PROTECT: assert property (wr_here_w && quiet_w |=> // see RQ2
    FLAGS_O[4:3] == $past(FLAGS_O[4:3]))
    else $error("instruction changed reset-cause flags");

  AST_ADD_FLAGS: assert property (OP_VALID_I && quiet_w // see RQ9
    && OP_KIND_I == CPSF_OP_ADD |=> FLAGS_O[`CPSF_C_BIT]
    == $past(chk_add_w[W]) && FLAGS_O[`CPSF_DC_BIT] == $past(chk_nib_w[4])
    && FLAGS_O[`CPSF_Z_BIT] == (RESULT_O == '0))
    else $error("add flags wrong");

  AST_SUB_BORROW: assert property (OP_VALID_I && quiet_w // see RQ10
    && OP_KIND_I == CPSF_OP_SUB |=> FLAGS_O[`CPSF_C_BIT]
    == $past(OPND_B_I >= OPND_A_I))
    else $error("borrow polarity wrong");

  AST_ROTATE: assert property (OP_VALID_I && quiet_w // see RQ11
    && OP_KIND_I == CPSF_OP_RRF |=> FLAGS_O[`CPSF_C_BIT]
    == $past(OPND_B_I[0]) && RESULT_O[W-1] == $past(FLAGS_O[0]))
    else $error("rotate carry wrong");

  AST_FLAG_DEST: assert property (wr_here_w && quiet_w && flag_op_w // see RQ1
    && OP_KIND_I == CPSF_OP_ZONLY |=> FLAGS_O[1:0] == $past(FLAGS_O[1:0])
    && FLAGS_O[`CPSF_Z_BIT] == (RESULT_O == '0))
    else $error("flag op data reached flags");

  AST_PLAIN_WRITE: assert property (wr_here_w && quiet_w && !flag_op_w
    |=> FLAGS_O[2:0] == $past(OPND_B_I[2:0])) // see RQ13
    else $error("plain write not stored");

endmodule

/* File: cpsf_status_reg_tb.sv */
`timescale 1ns/1ps

module cpsf_status_reg_tb;
  import cpsf_pkg::*;

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic por = 1'b0;
  logic op_valid;
  cpsf_op_type op_kind;
  logic dest;
  logic [7:0] opnd_a;
  logic [7:0] opnd_b;
  logic wdt_clear;
  logic sleep;
  logic wdt_timeout;
  logic [7:0] flags;
  logic [7:0] result;
  logic result_valid;
  int fails = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, device and far-side model
  always #5 clk_sys = ~clk_sys;

  cpsf_status_reg u_cpsf_status_reg (
    .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .POR_I(por),
    .OP_VALID_I(op_valid), .OP_KIND_I(op_kind), .DEST_FLAGS_I(dest),
    .OPND_A_I(opnd_a), .OPND_B_I(opnd_b), .WDT_CLEAR_I(wdt_clear),
    .SLEEP_I(sleep), .WDT_TIMEOUT_I(wdt_timeout), .FLAGS_O(flags),
    .RESULT_O(result), .RESULT_VALID_O(result_valid)
  );

  cpsf_core_model u_cpsf_core_model (
    .clk_i(clk_sys), .op_valid_o(op_valid), .op_kind_o(op_kind),
    .dest_o(dest), .a_o(opnd_a), .b_o(opnd_b), .clear_o(wdt_clear),
    .sleep_o(sleep), .timeout_o(wdt_timeout)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Instruction, then result, flags and one-cycle valid pulse
  task automatic op_chk(input cpsf_op_type k, input logic d,
                        input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] res, input logic [7:0] flg);
    u_cpsf_core_model.run_op(k, d, a, b);
    check(result, res);
    check(flags, flg);
    check({7'h00, result_valid}, 8'h01);
    @(negedge clk_sys);
    check({7'h00, result_valid}, 8'h00);
  endtask

  task automatic ev_chk(input logic c, input logic s, input logic t,
                        input logic [7:0] flg);
    u_cpsf_core_model.run_ev(c, s, t);
    check(flags, flg);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    check(flags, 8'h18);
    op_chk(CPSF_OP_ADD, 1'b0, 8'h0F, 8'h01, 8'h10, 8'h1A);
    op_chk(CPSF_OP_ADD, 1'b0, 8'hFF, 8'h01, 8'h00, 8'h1F);
    op_chk(CPSF_OP_SUB, 1'b0, 8'h03, 8'h05, 8'h02, 8'h1B);
    op_chk(CPSF_OP_SUB, 1'b0, 8'h05, 8'h03, 8'hFE, 8'h18);
    op_chk(CPSF_OP_RRF, 1'b0, 8'h00, 8'h01, 8'h00, 8'h19);
    op_chk(CPSF_OP_RLF, 1'b0, 8'h00, 8'h40, 8'h81, 8'h18);
    op_chk(CPSF_OP_RLF, 1'b0, 8'h00, 8'h80, 8'h00, 8'h19);
    op_chk(CPSF_OP_RRF, 1'b0, 8'h00, 8'h02, 8'h81, 8'h18);
    op_chk(CPSF_OP_WRITE, 1'b1, 8'h00, 8'hFF, 8'hFF, 8'h1F);
    op_chk(CPSF_OP_ADD, 1'b1, 8'h01, 8'h01, 8'h02, 8'h18);
    op_chk(CPSF_OP_WRITE, 1'b0, 8'h00, 8'h07, 8'h07, 8'h18);
    op_chk(CPSF_OP_WRITE, 1'b1, 8'h00, 8'h00, 8'h00, 8'h18);
    op_chk(CPSF_OP_ZONLY, 1'b0, 8'h00, 8'h00, 8'h00, 8'h1C);
    ev_chk(1'b0, 1'b1, 1'b0, 8'h14);
    op_chk(CPSF_OP_WRITE, 1'b1, 8'h00, 8'h18, 8'h18, 8'h10);
    ev_chk(1'b0, 1'b0, 1'b1, 8'h00);
    ev_chk(1'b1, 1'b0, 1'b0, 8'h18);
    ev_chk(1'b1, 1'b0, 1'b1, 8'h08);
    ev_chk(1'b0, 1'b1, 1'b0, 8'h10);
    op_chk(CPSF_OP_ZONLY, 1'b0, 8'h00, 8'h00, 8'h00, 8'h14);
    u_cpsf_core_model.run_pair();
    check(flags, 8'h1C);
    op_chk(CPSF_OP_ZONLY, 1'b1, 8'h00, 8'hFF, 8'hFF, 8'h18);
    op_chk(CPSF_OP_WRITE, 1'b1, 8'h00, 8'h07, 8'h07, 8'h1F);
    @(negedge clk_sys);
    por = 1'b1;
    @(negedge clk_sys);
    por = 1'b0;
    check(flags, 8'h18);
    print_verdict();
  end
endmodule
